// *** hw/sfs_pkg.sv ***
// What this block does
// - Idle: frame-select held High, transmit line Low with its driver disabled.
// - Idle serial clock rests at the polarity bit's level, Low in command mode.
// - Idle clock driver enabled as master, disabled as slave.
// - Enabled master with pending word drops frame-select and enables transmit driver.
// - Phase 0: master data half period after select falls, edge half later.
// - Polarity 0 phase 0: sample on rising, change on falling edges.
// - Phase 1: data and first edge half period after select falls.
// - Polarity 1 phase 0: sample on falling, change on rising edges.
// - Single word: select rises one period after the last sample.
// - Phase 0 back-to-back: select pulses High between words.
// - Phase 1 back-to-back: select stays Low between words.
// - Continuous transfer ends with select High one period after last sample.
// - Command frames open with an 8-bit control word; nothing received meanwhile.
// - Pending control byte starts a frame; select fall loads shifter, MSB out.
// - Select Low for whole command frame; receive line undriven during control.
// - Control latched rising, response driven falling, device latches rising.
// - Single command frame: select rises one period after last bit, word stored.
// - Continuous command frames: select Low, next control follows last response bit.
// - As command slave, first bit sampled on first rising edge after select falls.
// - Words shift out MSB first, 4 to 16 bits long.
package sfs_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int T_W    = 6;

    localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_TXDATA = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_RXDATA = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;

    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_SLV_BIT = 1;
    localparam int CTRL_CR_BIT  = 2;
    localparam int CTRL_POL_BIT = 3;
    localparam int CTRL_PHA_BIT = 4;
    localparam int CTRL_SZ_LSB  = 8;
    localparam int CTRL_DIV_LSB = 16;
    localparam int SZ_W         = 4;
    localparam int DIV_W        = 8;
    localparam int STAT_OVR_BIT = 3;

    localparam logic [SZ_W-1:0] SIZE_MIN_CODE = 4'h3;
    localparam int              CTRL_BITS     = 8;

    localparam logic [T_W-1:0] T_ONE          = 6'h01;
    localparam logic [T_W-1:0] SPI_FIRST_SAMP = 6'h02;
    localparam logic [T_W-1:0] FSS_TRAIL      = 6'h02;
    localparam logic [T_W-1:0] CR_CTRL_EDGES  = 6'h10;
    localparam logic [T_W-1:0] CR_RESP_FIRST  = 6'h13;
    localparam logic [T_W-1:0] CR_LAST_OFS    = 6'h11;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        SFS_IDLE = 2'b00,
        SFS_RUN  = 2'b01,
        SFS_END  = 2'b11
    } sfs_state_type;
endpackage : sfs_pkg

// *** hw/sfs_pin_if.sv ***
`timescale 1ns/1ps
interface sfs_pin_if;
    logic clk_lvl;
    logic clk_rise;
    logic clk_fall;
    logic fss_lvl;
    logic fss_rise;
    logic fss_fall;
    logic rx_lvl;

    modport src (output clk_lvl, clk_rise, clk_fall, fss_lvl, fss_rise, fss_fall, rx_lvl);
    modport dst (input  clk_lvl, clk_rise, clk_fall, fss_lvl, fss_rise, fss_fall, rx_lvl);
endinterface : sfs_pin_if

// *** hw/sfs_pin_sync.sv ***
`timescale 1ns/1ps
module sfs_pin_sync (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    // Raw pins
    input  wire logic serial_clock_pin_in,
    input  wire logic frame_select_pin_in,
    input  wire logic rx_data_pin_in,
    // Synchronised levels and edges
    sfs_pin_if.src    pins
);
    // Bit 0 serial clock, bit 1 frame-select, bit 2 receive data.
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic [1:0] last;
    } sfs_sync_type;

    sfs_sync_type s_r;
    sfs_sync_type s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = {rx_data_pin_in, frame_select_pin_in, serial_clock_pin_in};
        s_nxt.sync = s_r.meta;
        s_nxt.last = s_r.sync[1:0];
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Edges compare the second stage with a third; the first stage feeds nothing else.
    assign pins.clk_lvl  = s_r.sync[0];
    assign pins.clk_rise = s_r.sync[0] & ~s_r.last[0];
    assign pins.clk_fall = ~s_r.sync[0] & s_r.last[0];
    assign pins.fss_lvl  = s_r.sync[1];
    assign pins.fss_rise = s_r.sync[1] & ~s_r.last[1];
    assign pins.fss_fall = ~s_r.sync[1] & s_r.last[1];
    assign pins.rx_lvl   = s_r.sync[2];
endmodule : sfs_pin_sync

// *** hw/sfs_spi_frame_sequencer.sv ***
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module sfs_spi_frame_sequencer (
    // Clock and reset
    input  wire logic                        clk_sys_in,
    input  wire logic                        rst_n_in,
    // AXI4-Lite write address and data
    input  wire logic                        s_axi_awvalid_in,
    output wire logic                        s_axi_awready_out,
    input  wire logic [sfs_pkg::ADDR_W-1:0]  s_axi_awaddr_in,
    input  wire logic                        s_axi_wvalid_in,
    output wire logic                        s_axi_wready_out,
    input  wire logic [sfs_pkg::DATA_W-1:0]  s_axi_wdata_in,
    input  wire logic [3:0]                  s_axi_wstrb_in,
    // AXI4-Lite write response
    output wire logic                        s_axi_bvalid_out,
    input  wire logic                        s_axi_bready_in,
    output wire logic [1:0]                  s_axi_bresp_out,
    // AXI4-Lite read
    input  wire logic                        s_axi_arvalid_in,
    output wire logic                        s_axi_arready_out,
    input  wire logic [sfs_pkg::ADDR_W-1:0]  s_axi_araddr_in,
    output wire logic                        s_axi_rvalid_out,
    input  wire logic                        s_axi_rready_in,
    output wire logic [sfs_pkg::DATA_W-1:0]  s_axi_rdata_out,
    output wire logic [1:0]                  s_axi_rresp_out,
    // Serial pins
    input  wire logic                        serial_clock_pin_in,
    output wire logic                        serial_clock_pin_out,
    output wire logic                        serial_clock_pin_oe_out,
    input  wire logic                        frame_select_pin_in,
    output wire logic                        frame_select_pin_out,
    output wire logic                        frame_select_pin_oe_out,
    output wire logic                        tx_data_pin_out,
    output wire logic                        tx_data_pin_oe_out,
    input  wire logic                        rx_data_pin_in
);
    typedef struct packed {
        sfs_pkg::sfs_state_type          st;
        logic [sfs_pkg::T_W-1:0]         t;
        logic [sfs_pkg::DIV_W-1:0]       hcnt;
        logic [sfs_pkg::WORD_W-1:0]      word;
        logic [sfs_pkg::WORD_W-1:0]      rxsh;
        logic [sfs_pkg::WORD_W-1:0]      txh;
        logic [sfs_pkg::WORD_W-1:0]      rxh;
        logic                            txv;
        logic                            rxv;
        logic                            ovr;
        logic                            en;
        logic                            slv;
        logic                            cr;
        logic                            pol;
        logic                            pha;
        logic [sfs_pkg::SZ_W-1:0]        sz;
        logic [sfs_pkg::DIV_W-1:0]       div;
        logic                            clk_o;
        logic                            clk_oe;
        logic                            fss_o;
        logic                            fss_oe;
        logic                            tx_o;
        logic                            tx_oe;
        logic                            aw_free;
        logic                            w_free;
        logic                            ar_free;
        logic                            bvalid;
        logic                            rvalid;
        logic [1:0]                      bresp;
        logic [1:0]                      rresp;
        logic [sfs_pkg::DATA_W-1:0]      rdata;
        logic [sfs_pkg::ADDR_W-1:0]      awa;
        logic [sfs_pkg::DATA_W-1:0]      wd;
        logic [3:0]                      ws;
    } sfs_regs_type;

    sfs_regs_type s_r;
    sfs_regs_type s_nxt;

    sfs_pin_if pins ();

    sfs_pin_sync u_sync (
        .clk_sys_in          (clk_sys_in),
        .rst_n_in            (rst_n_in),
        .serial_clock_pin_in (serial_clock_pin_in),
        .frame_select_pin_in (frame_select_pin_in),
        .rx_data_pin_in      (rx_data_pin_in),
        .pins                (pins.src)
    );

    logic                        tick;
    logic                        pol_eff;
    logic                        samp_rise;
    logic                        samp_e;
    logic                        drv_e;
    logic                        push;
    logic [sfs_pkg::T_W-1:0]     nt;
    logic [sfs_pkg::T_W-1:0]     n2;
    logic [sfs_pkg::T_W-1:0]     cr_last;
    logic [4:0]                  nbits;
    logic [sfs_pkg::WORD_W-1:0]  rx_next;
    logic [sfs_pkg::WORD_W-1:0]  push_val;
    logic [sfs_pkg::WORD_W-1:0]  src_word;
    logic [sfs_pkg::SZ_W-1:0]    sz_wr;

    always_comb begin
        s_nxt    = s_r;
        tick     = (s_r.hcnt == '0);
        nt       = s_r.t + sfs_pkg::T_ONE;
        nbits    = {1'b0, s_r.sz} + 5'h01;
        n2       = {nbits, 1'b0};
        cr_last  = n2 + sfs_pkg::CR_LAST_OFS;
        pol_eff  = s_r.pol & ~s_r.cr;
        rx_next  = {s_r.rxsh[sfs_pkg::WORD_W-2:0], pins.rx_lvl};
        push     = 1'b0;
        push_val = rx_next;
        src_word = s_r.txv ? s_r.txh : '0;
        sz_wr    = s_r.wd[sfs_pkg::CTRL_SZ_LSB +: sfs_pkg::SZ_W];
        if (sz_wr < sfs_pkg::SIZE_MIN_CODE) begin
            sz_wr = sfs_pkg::SIZE_MIN_CODE;
        end
        samp_rise = s_r.cr | (s_r.pol == s_r.pha);
        samp_e    = samp_rise ? pins.clk_rise : pins.clk_fall;
        drv_e     = samp_rise ? pins.clk_fall : pins.clk_rise;

        // Register writes run once both address and data are held.
        if (s_r.aw_free && s_axi_awvalid_in) begin
            s_nxt.aw_free = 1'b0;
            s_nxt.awa     = s_axi_awaddr_in;
        end
        if (s_r.w_free && s_axi_wvalid_in) begin
            s_nxt.w_free = 1'b0;
            s_nxt.wd     = s_axi_wdata_in;
            s_nxt.ws     = s_axi_wstrb_in;
        end
        if (!s_r.aw_free && !s_r.w_free && !s_r.bvalid) begin
            s_nxt.bvalid  = 1'b1;
            s_nxt.aw_free = 1'b1;
            s_nxt.w_free  = 1'b1;
            s_nxt.bresp   = sfs_pkg::RESP_OKAY;
            if (s_r.awa == sfs_pkg::OFS_CTRL) begin
                if (s_r.ws[0]) begin
                    s_nxt.en  = s_r.wd[sfs_pkg::CTRL_EN_BIT];
                    s_nxt.slv = s_r.wd[sfs_pkg::CTRL_SLV_BIT];
                    s_nxt.cr  = s_r.wd[sfs_pkg::CTRL_CR_BIT];
                    s_nxt.pol = s_r.wd[sfs_pkg::CTRL_POL_BIT];
                    s_nxt.pha = s_r.wd[sfs_pkg::CTRL_PHA_BIT];
                end
                if (s_r.ws[1]) begin
                    s_nxt.sz = sz_wr;
                end
                if (s_r.ws[2]) begin
                    s_nxt.div = s_r.wd[sfs_pkg::CTRL_DIV_LSB +: sfs_pkg::DIV_W];
                end
            end else if (s_r.awa == sfs_pkg::OFS_TXDATA) begin
                // A write while a word is still pending is dropped; poll the full flag.
                if (!s_r.txv) begin
                    s_nxt.txh = s_r.wd[sfs_pkg::WORD_W-1:0];
                    s_nxt.txv = 1'b1;
                end
            end else if (s_r.awa == sfs_pkg::OFS_STATUS) begin
                if (s_r.wd[sfs_pkg::STAT_OVR_BIT]) begin
                    s_nxt.ovr = 1'b0;
                end
            end else if (s_r.awa != sfs_pkg::OFS_RXDATA) begin
                s_nxt.bresp = sfs_pkg::RESP_SLVERR;
            end
        end
        if (s_r.bvalid && s_axi_bready_in) begin
            s_nxt.bvalid = 1'b0;
        end

        // Register reads; reading the receive word frees it.
        if (s_r.ar_free && s_axi_arvalid_in) begin
            s_nxt.ar_free = 1'b0;
            s_nxt.rvalid  = 1'b1;
            s_nxt.rresp   = sfs_pkg::RESP_OKAY;
            s_nxt.rdata   = '0;
            if (s_axi_araddr_in == sfs_pkg::OFS_CTRL) begin
                s_nxt.rdata = {8'h00, s_r.div, 4'h0, s_r.sz, 3'h0,
                               s_r.pha, s_r.pol, s_r.cr, s_r.slv, s_r.en};
            end else if (s_axi_araddr_in == sfs_pkg::OFS_TXDATA) begin
                s_nxt.rdata = {16'h0000, s_r.txh};
            end else if (s_axi_araddr_in == sfs_pkg::OFS_RXDATA) begin
                s_nxt.rdata = {16'h0000, s_r.rxh};
                s_nxt.rxv   = 1'b0;
            end else if (s_axi_araddr_in == sfs_pkg::OFS_STATUS) begin
                s_nxt.rdata = {28'h0000000, s_r.ovr,
                               (s_r.st != sfs_pkg::SFS_IDLE) | (s_r.slv & ~pins.fss_lvl),
                               s_r.rxv, s_r.txv};
            end else begin
                s_nxt.rresp = sfs_pkg::RESP_SLVERR;
            end
        end else if (s_r.rvalid && s_axi_rready_in) begin
            s_nxt.rvalid  = 1'b0;
            s_nxt.ar_free = 1'b1;
        end

        if (!s_r.en) begin
            s_nxt.st     = sfs_pkg::SFS_IDLE;
            s_nxt.clk_o  = pol_eff;
            s_nxt.clk_oe = ~s_r.slv;
            s_nxt.fss_o  = 1'b1;
            s_nxt.fss_oe = ~s_r.slv;
            s_nxt.tx_o   = 1'b0;
            s_nxt.tx_oe  = 1'b0;
        end else if (s_r.slv) begin
            // Slave: pin edges seen through the synchroniser drive the shifter.
            s_nxt.st     = sfs_pkg::SFS_IDLE;
            s_nxt.clk_oe = 1'b0;
            s_nxt.fss_oe = 1'b0;
            if (pins.fss_fall) begin
                s_nxt.t     = '0;
                s_nxt.tx_oe = 1'b1;
                s_nxt.word  = src_word;
                s_nxt.txv   = s_nxt.txv & ~s_r.txv;
                s_nxt.rxsh  = '0;
                if (!s_r.pha || s_r.cr) begin
                    s_nxt.tx_o = src_word[s_r.sz];
                    s_nxt.word = src_word << 1;
                end
            end else if (!pins.fss_lvl) begin
                if (samp_e) begin
                    s_nxt.rxsh = rx_next;
                    s_nxt.t    = nt;
                    if (nt == {1'b0, nbits}) begin
                        push  = 1'b1;
                        s_nxt.t = '0;
                        if (s_r.pha && !s_r.cr) begin
                            s_nxt.word = src_word;
                            s_nxt.txv  = s_nxt.txv & ~s_r.txv;
                        end
                    end
                end else if (drv_e) begin
                    s_nxt.tx_o = s_r.word[s_r.sz];
                    s_nxt.word = s_r.word << 1;
                end
            end
            if (pins.fss_rise) begin
                s_nxt.tx_o  = 1'b0;
                s_nxt.tx_oe = 1'b0;
            end
        end else begin
            s_nxt.clk_oe = 1'b1;
            s_nxt.fss_oe = 1'b1;
            if (s_r.st != sfs_pkg::SFS_IDLE) begin
                s_nxt.hcnt = tick ? s_r.div : s_r.hcnt - 8'h01;
            end
            case (s_r.st)
                sfs_pkg::SFS_IDLE: begin
                    s_nxt.clk_o = pol_eff;
                    s_nxt.fss_o = 1'b1;
                    s_nxt.tx_o  = 1'b0;
                    s_nxt.tx_oe = 1'b0;
                    if (s_r.txv) begin
                        s_nxt.st    = sfs_pkg::SFS_RUN;
                        s_nxt.t     = '0;
                        s_nxt.hcnt  = s_r.div;
                        s_nxt.fss_o = 1'b0;
                        s_nxt.tx_oe = 1'b1;
                        s_nxt.txv   = 1'b0;
                        s_nxt.rxsh  = '0;
                        s_nxt.word  = s_r.txh;
                        if (s_r.cr) begin
                            s_nxt.tx_o = s_r.txh[sfs_pkg::CTRL_BITS-1];
                            s_nxt.word = s_r.txh << 1;
                        end
                    end
                end
                sfs_pkg::SFS_RUN: begin
                    if (tick && !s_r.cr) begin
                        s_nxt.t = nt;
                        // Half period steps: odd steps drive, even steps sample.
                        s_nxt.clk_o = s_r.pol ^ (s_r.pha ? (nt[0] && nt < n2)
                            : (!nt[0] && nt >= sfs_pkg::SPI_FIRST_SAMP && nt <= n2));
                        if (nt[0] && nt < n2) begin
                            s_nxt.tx_o = s_r.word[s_r.sz];
                            s_nxt.word = s_r.word << 1;
                        end
                        if (!nt[0] && nt >= sfs_pkg::SPI_FIRST_SAMP && nt <= n2) begin
                            s_nxt.rxsh = rx_next;
                        end
                        if (nt == n2) begin
                            push = 1'b1;
                            if (s_r.pha && s_r.txv) begin
                                s_nxt.t    = '0;
                                s_nxt.word = s_r.txh;
                                s_nxt.txv  = 1'b0;
                                s_nxt.rxsh = '0;
                            end
                        end
                        if (nt == n2 + sfs_pkg::FSS_TRAIL) begin
                            s_nxt.st    = sfs_pkg::SFS_END;
                            s_nxt.fss_o = 1'b1;
                            s_nxt.tx_o  = 1'b0;
                            s_nxt.tx_oe = 1'b0;
                        end
                    end else if (tick) begin
                        s_nxt.t     = nt;
                        s_nxt.clk_o = nt[0] && nt <= cr_last;
                        if (!nt[0] && nt < sfs_pkg::CR_CTRL_EDGES) begin
                            s_nxt.tx_o = s_r.word[sfs_pkg::CTRL_BITS-1];
                            s_nxt.word = s_r.word << 1;
                        end
                        if (nt == sfs_pkg::CR_CTRL_EDGES) begin
                            s_nxt.tx_o = 1'b0;
                        end
                        if (nt[0] && nt >= sfs_pkg::CR_RESP_FIRST && nt <= cr_last) begin
                            s_nxt.rxsh = rx_next;
                        end
                        if (nt == cr_last + sfs_pkg::T_ONE && s_r.txv) begin
                            push       = 1'b1;
                            push_val   = s_r.rxsh;
                            s_nxt.t    = '0;
                            s_nxt.tx_o = s_r.txh[sfs_pkg::CTRL_BITS-1];
                            s_nxt.word = s_r.txh << 1;
                            s_nxt.txv  = 1'b0;
                            s_nxt.rxsh = '0;
                        end
                        if (nt == cr_last + sfs_pkg::FSS_TRAIL) begin
                            push        = 1'b1;
                            push_val    = s_r.rxsh;
                            s_nxt.st    = sfs_pkg::SFS_END;
                            s_nxt.fss_o = 1'b1;
                            s_nxt.tx_oe = 1'b0;
                        end
                    end
                end
                sfs_pkg::SFS_END: begin
                    // A half period of High before the next frame may open.
                    if (tick) begin
                        s_nxt.st = sfs_pkg::SFS_IDLE;
                    end
                end
                default: begin
                    s_nxt.st = sfs_pkg::SFS_IDLE;
                end
            endcase
        end

        // The received word wins over a read in the same cycle; an unread one is kept.
        if (push) begin
            if (s_nxt.rxv) begin
                s_nxt.ovr = 1'b1;
            end else begin
                s_nxt.rxh = push_val;
            end
            s_nxt.rxv = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r         <= '0;
            s_r.sz      <= sfs_pkg::SIZE_MIN_CODE;
            s_r.clk_oe  <= 1'b1;
            s_r.fss_o   <= 1'b1;
            s_r.fss_oe  <= 1'b1;
            s_r.aw_free <= 1'b1;
            s_r.w_free  <= 1'b1;
            s_r.ar_free <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready_out       = s_r.aw_free;
    assign s_axi_wready_out        = s_r.w_free;
    assign s_axi_bvalid_out        = s_r.bvalid;
    assign s_axi_bresp_out         = s_r.bresp;
    assign s_axi_arready_out       = s_r.ar_free;
    assign s_axi_rvalid_out        = s_r.rvalid;
    assign s_axi_rdata_out         = s_r.rdata;
    assign s_axi_rresp_out         = s_r.rresp;
    assign serial_clock_pin_out    = s_r.clk_o;
    assign serial_clock_pin_oe_out = s_r.clk_oe;
    assign frame_select_pin_out    = s_r.fss_o;
    assign frame_select_pin_oe_out = s_r.fss_oe;
    assign tx_data_pin_out         = s_r.tx_o;
    assign tx_data_pin_oe_out      = s_r.tx_oe;
endmodule : sfs_spi_frame_sequencer

// *** tb/sfs_assertions.sv ***
`timescale 1ns/1ps
module sfs_assertions (
    // Clock, reset and serial pin outputs of the sequencer
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic serial_clock_pin_out,
    input wire logic serial_clock_pin_oe_out,
    input wire logic frame_select_pin_out,
    input wire logic frame_select_pin_oe_out,
    input wire logic tx_data_pin_out,
    input wire logic tx_data_pin_oe_out
);
    wire ck = serial_clock_pin_out, ck_oe = serial_clock_pin_oe_out, fs = frame_select_pin_out;
    wire fs_oe = frame_select_pin_oe_out, tx = tx_data_pin_out, tx_oe = tx_data_pin_oe_out;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    idle_select_a: assert property (fs_oe && !tx_oe |-> fs)
        else $error("select low while idle");
    idle_tx_a: assert property (!tx_oe |-> !tx)
        else $error("idle tx not low");
    clk_drive_a: assert property (ck_oe == fs_oe)
        else $error("clock driver wrong");
    start_drive_a: assert property (fs_oe && $fell(fs) |-> tx_oe)
        else $error("tx driver off at start");
    drive_start_a: assert property (fs_oe && $rose(tx_oe) |-> $fell(fs))
        else $error("tx driver on without start");
    first_edge_a: assert property ($fell(fs) |-> $stable(ck))
        else $error("clock edge at select fall");
    clk_rest_a: assert property ($rose(fs) |-> $stable(ck)[*2])
        else $error("clock moved after frame");
    select_gap_a: assert property ($rose(fs) |=> fs)
        else $error("select pulse too short");
endmodule : sfs_assertions
bind sfs_spi_frame_sequencer sfs_assertions u_chk (.clk_sys_in, .rst_n_in,
    .serial_clock_pin_out, .serial_clock_pin_oe_out, .frame_select_pin_out,
    .frame_select_pin_oe_out, .tx_data_pin_out, .tx_data_pin_oe_out);

// *** tb/sfs_slave_model.sv ***
`timescale 1ns/1ps
module sfs_slave_model (
    // Serial pins and mode seen by the slave
    input  wire logic        sclk_in,
    input  wire logic        sel_n_in,
    input  wire logic        mosi_in,
    input  wire logic        pol_in,
    input  wire logic        pha_in,
    input  wire logic [15:0] word_in,
    output wire logic        miso_out,
    output logic      [15:0] got_out
);
    logic [16:0] sh_r;
    always @(negedge sel_n_in)
        sh_r <= pha_in ? {~word_in[15], word_in} : {word_in, 1'b0};
    always @(sclk_in)
        if (!sel_n_in && ((pol_in == pha_in) == sclk_in))
            got_out <= {got_out[14:0], mosi_in};
        else if (!sel_n_in)
            sh_r <= {sh_r[15:0], 1'b0};
    // A released line shows the inverse, so a stale bit never passes for data.
    assign miso_out = sel_n_in ? ~sh_r[16] : sh_r[16];
endmodule : sfs_slave_model

// *** tb/tb_spi_frame_sequencer.sv ***
`timescale 1ns/1ps
module tb_spi_frame_sequencer;
    logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
    logic        arv = 1'b0, rrdy = 1'b0, pol = 1'b0, pha = 1'b0;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, d;
    logic [15:0] sw = 16'h5a00;
    wire         awr, wrr, bv, arr, rv, ck, ck_oe, fs, fs_oe, tx, tx_oe, rx;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [15:0] got;
    int          n_errors = 0, compares = 0, falls = 0;
    always #4 clk_sys_in = ~clk_sys_in;
    always @(negedge fs) falls++;
    sfs_spi_frame_sequencer dut (.clk_sys_in, .rst_n_in, .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wrr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .serial_clock_pin_in(ck), .serial_clock_pin_out(ck),
        .serial_clock_pin_oe_out(ck_oe), .frame_select_pin_in(fs), .frame_select_pin_out(fs),
        .frame_select_pin_oe_out(fs_oe), .tx_data_pin_out(tx), .tx_data_pin_oe_out(tx_oe),
        .rx_data_pin_in(rx));
    sfs_slave_model u_slave (.sclk_in(ck), .sel_n_in(fs), .mosi_in(tx), .pol_in(pol),
        .pha_in(pha), .word_in(sw), .miso_out(rx), .got_out(got));
    task automatic chk(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
        @(posedge clk_sys_in);
        {awv, wv, brdy, awa, wd} <= {3'b111, a, v};
        do begin
            @(posedge clk_sys_in);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
        end while (!bv);
        brdy <= 1'b0;
        chk(bresp, r);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge clk_sys_in);
        {arv, rrdy, ara} <= {2'b11, a};
        do begin
            @(posedge clk_sys_in);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rrdy <= 1'b0;
        d = rdata;
        chk(rresp, sfs_pkg::RESP_OKAY);
    endtask : rd
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (5) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        wr(12'h040, 32'h0, sfs_pkg::RESP_SLVERR);
        for (int m = 0; m < 4; m++) begin
            {pha, pol} <= m[1:0];
            falls = 0;
            // Eight-bit words, half period of four clocks so the synchroniser keeps up.
            wr(sfs_pkg::OFS_CTRL, 32'h00030701 | 32'(m << 3), sfs_pkg::RESP_OKAY);
            wr(sfs_pkg::OFS_TXDATA, 32'h0a5, sfs_pkg::RESP_OKAY);
            do rd(sfs_pkg::OFS_STATUS); while (d[0]);
            wr(sfs_pkg::OFS_TXDATA, 32'h0c3, sfs_pkg::RESP_OKAY);
            do rd(sfs_pkg::OFS_STATUS); while (d[2] || d[0]);
            chk(falls, (m > 1) ? 1 : 2);
            chk(got[7:0], 8'hc3);
            chk(ck, m[0]);
            chk({ck_oe, fs, tx, tx_oe}, 4'b1100);
            rd(sfs_pkg::OFS_RXDATA);
            chk(d[7:0], 8'h5a);
        end
        // Two command frames back to back; nine falling edges pass before the answer.
        {pha, pol, sw} <= {2'b00, 16'h0050};
        falls = 0;
        wr(sfs_pkg::OFS_CTRL, 32'h00030305, sfs_pkg::RESP_OKAY);
        wr(sfs_pkg::OFS_TXDATA, 32'h096, sfs_pkg::RESP_OKAY);
        do rd(sfs_pkg::OFS_STATUS); while (d[0]);
        wr(sfs_pkg::OFS_TXDATA, 32'h069, sfs_pkg::RESP_OKAY);
        do rd(sfs_pkg::OFS_STATUS); while (d[2] || d[0]);
        chk(falls, 1);
        chk(got[12:0], {8'h69, 5'h00});
        rd(sfs_pkg::OFS_RXDATA);
        chk(d[15:0], 16'h000a);
        summarize();
    end
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
endmodule : tb_spi_frame_sequencer
